// >>> ams_pkg.sv
package ams_pkg;

   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [11:0] OFS_CMD      = 12'h000;
   localparam logic [11:0] OFS_IMM      = 12'h004;
   localparam logic [11:0] OFS_ACC      = 12'h008;
   localparam logic [11:0] OFS_STACK    = 12'h00C;
   localparam logic [11:0] OFS_FLAGS    = 12'h010;
   localparam logic [11:0] OFS_IRQ_STAT = 12'h014;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h018;
   localparam logic [11:0] OFS_MEM      = 12'h100;
   localparam int          WORD_BYTES   = 4;

   // ----------------------------------------
   // fields
   // ----------------------------------------
   localparam int CMD_OP_LSB  = 0;
   localparam int CMD_SRC_LSB = 4;
   localparam int CMD_ADR_LSB = 8;
   localparam int FLG_ZERO    = 0;
   localparam int FLG_BOR16   = 1;
   localparam int FLG_BOR32   = 2;
   localparam int FLG_NEG     = 3;
   localparam int FLG_BADPTR  = 4;
   localparam int FLG_FVALID  = 5;
   localparam int FLG_SIGNERR = 6;
   localparam int FLG_UNDER   = 7;
   localparam int FLG_BADOP   = 8;
   localparam int FLG_BUSY    = 9;
   localparam int IRQ_DONE    = 0;
   localparam int IRQ_BADOP   = 1;
   localparam int IRQ_BADPTR  = 2;
   localparam int IRQ_UNDER   = 3;
   localparam int IRQ_W       = 4;

   // ----------------------------------------
   // arithmetic constants
   // ----------------------------------------
   localparam logic [3:0]        BCD_NINE    = 4'h9;
   localparam logic [4:0]        BCD_MAX     = 5'h09;
   localparam logic [4:0]        BCD_ADJ     = 5'h06;
   localparam logic [31:0]       NINES32     = 32'h9999_9999;
   localparam logic [47:0]       NINES48     = 48'h9999_9999_9999;
   localparam logic [7:0]        EXP_ALL1    = 8'hFF;
   localparam logic signed [9:0] EXP_BIAS    = 10'h07F;
   localparam logic signed [9:0] EXP_TOP     = 10'h0FF;
   localparam logic [2:0]        DIG_LAST    = 3'h7;

   typedef enum logic [2:0] {
      OP_BCD_DIFFERENCE_WIDE  = 3'b000,
      OP_SUB16 = 3'b001,
      OP_REAL_DIFFERENCE  = 3'b010,
      OP_MUL16 = 3'b011,
      OP_BCD_PRODUCT_WIDE  = 3'b100,
      OP_REAL_PRODUCT  = 3'b101
   } ams_op_e;

   typedef enum logic [1:0] {
      SRC_MEM = 2'b00,
      SRC_PTR = 2'b01,
      SRC_IMM = 2'b10
   } ams_src_e;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FETCH = 2'b01,
      ST_EXEC  = 2'b10,
      ST_MUL   = 2'b11
   } ams_state_e;

   function automatic logic [31:0] ams_nines(input logic [31:0] v);
      logic [31:0] q;
      q = '0;
      for (int i = 0; i < 8; i++)
      begin
         q[i*4 +: 4] = BCD_NINE - v[i*4 +: 4];
      end
      return q;
   endfunction

   function automatic logic ams_bcd_ok(input logic [31:0] v);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         if (v[i*4 +: 4] > BCD_NINE)
         begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

endpackage

// >>> ams_bcd_add.sv
`timescale 1ns/10ps
module ams_bcd_add
   import ams_pkg::*;
#(
   parameter int DIGITS = 16
)
(
   input  wire logic [4*DIGITS-1:0] a,
   input  wire logic [4*DIGITS-1:0] b,
   input  wire logic                cin,
   output logic      [4*DIGITS-1:0] sum,
   output logic                     cout
);

   logic [DIGITS:0] c;

   assign c[0] = cin;
   assign cout = c[DIGITS];

   // ----------------------------------------
   // ripple of decimal digits
   // ----------------------------------------
   for (genvar g = 0; g < DIGITS; g++)
   begin : g_dig
      logic [4:0] raw;
      logic [4:0] adj;
      assign raw = {1'b0, a[g*4 +: 4]} + {1'b0, b[g*4 +: 4]} + {4'h0, c[g]};
      assign c[g+1] = (raw > BCD_MAX);
      assign adj = raw + BCD_ADJ;
      assign sum[g*4 +: 4] = c[g+1] ? adj[3:0] : raw[3:0];
   end

endmodule

// >>> ams_fp.sv
`timescale 1ns/10ps
module ams_fp
   import ams_pkg::*;
(
   input  wire logic [31:0] op_a,
   input  wire logic [31:0] op_b,
   output logic      [31:0] diff,
   output logic             diff_under,
   output logic             diff_ovf,
   output logic      [31:0] prod,
   output logic             prod_under,
   output logic             prod_ovf,
   output logic             non_real
);

   // subnormals are taken as zero and results truncate; this keeps the
   // unit small at the price of the last bit of accuracy
   always_comb
   begin
      logic [31:0]       x;
      logic [31:0]       y;
      logic [23:0]       mx;
      logic [23:0]       my;
      logic [24:0]       s;
      logic signed [9:0] e;
      logic [9:0]        sh;
      logic [47:0]       p;
      logic signed [9:0] ep;
      logic [22:0]       fr;
      x = op_a;
      y = {~op_b[31], op_b[30:0]};
      if (op_b[30:0] > op_a[30:0])
      begin
         x = y;
         y = op_a;
      end
      mx = (x[30:23] != 8'h00) ? {1'b1, x[22:0]} : 24'h00_0000;
      my = (y[30:23] != 8'h00) ? {1'b1, y[22:0]} : 24'h00_0000;
      sh = {2'b00, x[30:23]} - {2'b00, y[30:23]};
      my = (sh > 10'h018) ? 24'h00_0000 : (my >> sh);
      s = (x[31] == y[31]) ? ({1'b0, mx} + {1'b0, my}) : ({1'b0, mx} - {1'b0, my});
      e = $signed({2'b00, x[30:23]});
      if (s[24])
      begin
         s = s >> 1;
         e = e + 10'sh001;
      end
      for (int i = 0; i < 24; i++)
      begin
         if (!s[23] && (s != 25'h000_0000))
         begin
            s = {s[23:0], 1'b0};
            e = e - 10'sh001;
         end
      end
      non_real = (&op_a[30:23]) | (&op_b[30:23]);
      diff_under = (s != 25'h000_0000) && (e <= 10'sh000);
      diff_ovf = (s != 25'h000_0000) && (e >= EXP_TOP);
      if ((s == 25'h000_0000) || diff_under)
         diff = 32'h0000_0000;
      else if (diff_ovf)
         diff = {x[31], EXP_ALL1, 23'h00_0000};
      else
         diff = {x[31], e[7:0], s[22:0]};
      // product
      mx = (op_a[30:23] != 8'h00) ? {1'b1, op_a[22:0]} : 24'h00_0000;
      my = (op_b[30:23] != 8'h00) ? {1'b1, op_b[22:0]} : 24'h00_0000;
      p = mx * my;
      ep = $signed({2'b00, op_a[30:23]}) + $signed({2'b00, op_b[30:23]}) - EXP_BIAS;
      fr = p[45:23];
      if (p[47])
      begin
         fr = p[46:24];
         ep = ep + 10'sh001;
      end
      prod_under = (p != 48'h0000_0000_0000) && (ep <= 10'sh000);
      prod_ovf = (p != 48'h0000_0000_0000) && (ep >= EXP_TOP);
      if ((p == 48'h0000_0000_0000) || prod_under)
         prod = 32'h0000_0000;
      else if (prod_ovf)
         prod = {op_a[31] ^ op_b[31], EXP_ALL1, 23'h00_0000};
      else
         prod = {op_a[31] ^ op_b[31], ep[7:0], fr};
   end

endmodule

// >>> ams_unit.sv
// The register addresses and the AHB-Lite register port were decided locally.
`timescale 1ns/10ps
// Operation
// - wide BCD subtract, operand pair or immediate
// - zero flag when accumulator result is zero
// - 16-bit borrow flag on 16-bit subtract
// - separate 32-bit borrow flag on wide subtract
// - negative flag after subtract or multiply
// - bad operand flag on non-BCD digit
// - flags valid until next affecting instruction
// - real subtract: operand minus accumulator
// - bad pointer flag on invalid pointed address
// - float validity flag after real ops
// - sign error flag on float overflow
// - underflow flag on float underflow
// - bad operand flag on non-real operand
// - 16-bit BCD multiply, product to accumulator
// - wide BCD multiply, memory pair only
// - low digits to accumulator, upper pushed
// - real multiply into accumulator
module ams_unit
   import ams_pkg::*;
#(
   parameter int MEM_WORDS = 32
)
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic      [31:0] hrdata,
   output logic             hresp,
   output logic             irq,
   output logic             busy,
   output logic             zero_flag,
   output logic             borrow16_flag,
   output logic             borrow32_flag,
   output logic             negative_flag,
   output logic             bad_pointer_flag,
   output logic             float_validity_flag,
   output logic             sign_error_flag,
   output logic             underflow_flag,
   output logic             bad_operand_flag
);

   localparam int          AW      = $clog2(MEM_WORDS);
   localparam logic [11:0] MEM_END = OFS_MEM + 12'(MEM_WORDS * WORD_BYTES);
   localparam logic [15:0] PTR_MAX = 16'(MEM_WORDS - 2);

   typedef struct packed {
      ams_state_e                 st;
      ams_op_e                    op;
      ams_src_e                   src;
      logic [AW-1:0]              adr;
      logic [31:0]                imm;
      logic [31:0]                acc;
      logic [31:0]                stack;
      logic [31:0]                opnd;
      logic [63:0]                prod;
      logic [31:0]                mcand;
      logic [31:0]                mplier;
      logic [2:0]                 dcnt;
      logic [3:0]                 rep;
      logic                       zero;
      logic                       bor16;
      logic                       bor32;
      logic                       neg;
      logic                       badptr;
      logic                       fvalid;
      logic                       signerr;
      logic                       under;
      logic                       badop;
      logic                       busy;
      logic [IRQ_W-1:0]           irq_stat;
      logic [IRQ_W-1:0]           irq_mask;
      logic                       irq;
      logic                       dp_wr;
      logic                       dp_rd;
      logic [11:0]                dp_adr;
      logic                       rdy;
      logic                       resp;
      logic [31:0]                rdata;
      logic [MEM_WORDS-1:0][15:0] mem;
   } ams_regs_s;

   ams_regs_s   r;
   ams_regs_s   next_r;
   logic [63:0] add_a;
   logic [63:0] add_b;
   logic        add_cin;
   logic [63:0] add_sum;
   logic        add_cout;
   logic [31:0] sub_nines;
   logic [31:0] fp_diff;
   logic        fp_diff_under;
   logic        fp_diff_ovf;
   logic [31:0] fp_prod;
   logic        fp_prod_under;
   logic        fp_prod_ovf;
   logic        fp_non_real;

   // ----------------------------------------
   // shared decimal adder
   // ----------------------------------------
   // subtraction is a + nines(b) + 1; the upper digits of the adder get
   // 0 and 9s so the final carry out is the inverted borrow
   assign sub_nines = ams_nines(r.opnd);
   assign add_cin = (r.st == ST_EXEC);
   assign add_a = (r.st != ST_EXEC) ? r.prod :
                  (r.op == OP_SUB16) ? {48'h0000_0000_0000, r.acc[15:0]} :
                  {32'h0000_0000, r.acc};
   assign add_b = (r.st != ST_EXEC) ? {32'h0000_0000, r.mcand} :
                  (r.op == OP_SUB16) ? {NINES48, sub_nines[15:0]} :
                  {NINES32, sub_nines};

   ams_bcd_add #(
      .DIGITS (16)
   ) u_add (
      .a    (add_a),
      .b    (add_b),
      .cin  (add_cin),
      .sum  (add_sum),
      .cout (add_cout)
   );

   ams_fp u_fp (
      .op_a       (r.opnd),
      .op_b       (r.acc),
      .diff       (fp_diff),
      .diff_under (fp_diff_under),
      .diff_ovf   (fp_diff_ovf),
      .prod       (fp_prod),
      .prod_under (fp_prod_under),
      .prod_ovf   (fp_prod_ovf),
      .non_real   (fp_non_real)
   );

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      logic [31:0]   rd;
      logic [31:0]   fv;
      logic [11:0]   moff;
      logic [15:0]   pv;
      logic [AW-1:0] ea;
      logic [31:0]   res;
      logic [31:0]   acc_chk;
      rd = 32'h0000_0000;
      fv = 32'h0000_0000;
      moff = 12'h000;
      pv = 16'h0000;
      ea = r.adr;
      res = 32'h0000_0000;
      acc_chk = r.acc;
      next_r = r;
      next_r.dp_wr = 1'b0;
      next_r.dp_rd = 1'b0;
      next_r.rdy = 1'b1;
      next_r.resp = 1'b0;

      // bus address phase; reads take one wait state
      if (hsel && htrans[1] && hready)
      begin
         next_r.dp_adr = haddr[11:0];
         next_r.dp_wr = hwrite;
         next_r.dp_rd = !hwrite;
         next_r.rdy = hwrite;
      end

      // read data phase
      if (r.dp_rd)
      begin
         fv[FLG_ZERO] = r.zero;
         fv[FLG_BOR16] = r.bor16;
         fv[FLG_BOR32] = r.bor32;
         fv[FLG_NEG] = r.neg;
         fv[FLG_BADPTR] = r.badptr;
         fv[FLG_FVALID] = r.fvalid;
         fv[FLG_SIGNERR] = r.signerr;
         fv[FLG_UNDER] = r.under;
         fv[FLG_BADOP] = r.badop;
         fv[FLG_BUSY] = r.busy;
         moff = r.dp_adr - OFS_MEM;
         case (r.dp_adr)
            OFS_CMD:      rd = {30'h0000_0000, r.st};
            OFS_IMM:      rd = r.imm;
            OFS_ACC:      rd = r.acc;
            OFS_STACK:    rd = r.stack;
            OFS_FLAGS:    rd = fv;
            OFS_IRQ_STAT: rd = {{(32-IRQ_W){1'b0}}, r.irq_stat};
            OFS_IRQ_MASK: rd = {{(32-IRQ_W){1'b0}}, r.irq_mask};
            default:
            begin
               if (r.dp_adr >= OFS_MEM && r.dp_adr < MEM_END)
               begin
                  rd = {16'h0000, r.mem[moff[AW+1:2]]};
               end
            end
         endcase
         next_r.rdata = rd;
      end

      // write data phase
      if (r.dp_wr)
      begin
         moff = r.dp_adr - OFS_MEM;
         case (r.dp_adr)
            OFS_CMD:
            begin
               // a command while busy is dropped
               if (r.st == ST_IDLE)
               begin
                  next_r.op = ams_op_e'(hwdata[CMD_OP_LSB +: 3]);
                  next_r.src = ams_src_e'(hwdata[CMD_SRC_LSB +: 2]);
                  next_r.adr = hwdata[CMD_ADR_LSB +: AW];
                  next_r.st = ST_FETCH;
               end
            end
            OFS_IMM:      next_r.imm = hwdata;
            OFS_ACC:
            begin
               if (r.st == ST_IDLE)
               begin
                  next_r.acc = hwdata;
               end
            end
            OFS_IRQ_STAT: next_r.irq_stat = r.irq_stat & ~hwdata[IRQ_W-1:0];
            OFS_IRQ_MASK: next_r.irq_mask = hwdata[IRQ_W-1:0];
            default:
            begin
               if (r.dp_adr >= OFS_MEM && r.dp_adr < MEM_END)
               begin
                  next_r.mem[moff[AW+1:2]] = hwdata[15:0];
               end
            end
         endcase
      end

      // operation engine; each op touches only its own flags
      case (r.st)
         ST_IDLE:
         begin
         end
         ST_FETCH:
         begin
            next_r.st = ST_EXEC;
            if (((r.op == OP_BCD_PRODUCT_WIDE) && (r.src != SRC_MEM)) ||
                ((r.op == OP_SUB16) && (r.src == SRC_IMM)))
            begin
               next_r.badop = 1'b1;
               next_r.irq_stat[IRQ_BADOP] = 1'b1;
               next_r.irq_stat[IRQ_DONE] = 1'b1;
               next_r.st = ST_IDLE;
            end
            else if (r.src == SRC_PTR)
            begin
               pv = r.mem[r.adr];
               next_r.badptr = (pv > PTR_MAX);
               ea = pv[AW-1:0];
               if (pv > PTR_MAX)
               begin
                  next_r.irq_stat[IRQ_BADPTR] = 1'b1;
                  next_r.irq_stat[IRQ_DONE] = 1'b1;
                  next_r.st = ST_IDLE;
               end
            end
            if (r.src == SRC_IMM)
               next_r.opnd = r.imm;
            else
               next_r.opnd = {r.mem[AW'(ea + 1'b1)], r.mem[ea]};
            if ((r.op == OP_SUB16) || (r.op == OP_MUL16))
            begin
               next_r.opnd[31:16] = 16'h0000;
            end
         end
         ST_EXEC:
         begin
            next_r.st = ST_IDLE;
            if ((r.op == OP_SUB16) || (r.op == OP_MUL16))
            begin
               acc_chk = {16'h0000, r.acc[15:0]};
            end
            case (r.op)
               OP_BCD_DIFFERENCE_WIDE, OP_SUB16, OP_MUL16, OP_BCD_PRODUCT_WIDE:
               begin
                  next_r.badop = !(ams_bcd_ok(acc_chk) && ams_bcd_ok(r.opnd));
                  if (next_r.badop)
                  begin
                     next_r.irq_stat[IRQ_BADOP] = 1'b1;
                  end
                  else if ((r.op == OP_BCD_DIFFERENCE_WIDE) || (r.op == OP_SUB16))
                  begin
                     res = (r.op == OP_SUB16) ? {16'h0000, add_sum[15:0]} : add_sum[31:0];
                     next_r.acc = res;
                     next_r.zero = (res == 32'h0000_0000);
                     next_r.neg = !add_cout;
                     if (r.op == OP_SUB16)
                        next_r.bor16 = !add_cout;
                     else
                        next_r.bor32 = !add_cout;
                  end
                  else
                  begin
                     // multiply one multiplier digit at a time, msd first
                     next_r.prod = 64'h0000_0000_0000_0000;
                     next_r.mcand = acc_chk;
                     next_r.mplier = r.opnd;
                     next_r.dcnt = 3'h0;
                     next_r.rep = 4'h0;
                     next_r.st = ST_MUL;
                  end
               end
               OP_REAL_DIFFERENCE, OP_REAL_PRODUCT:
               begin
                  next_r.badop = fp_non_real;
                  if (fp_non_real)
                  begin
                     next_r.irq_stat[IRQ_BADOP] = 1'b1;
                  end
                  else
                  begin
                     res = (r.op == OP_REAL_DIFFERENCE) ? fp_diff : fp_prod;
                     next_r.acc = res;
                     next_r.zero = (res[30:0] == 31'h0000_0000);
                     next_r.neg = res[31];
                     next_r.fvalid = (res[30:23] != EXP_ALL1);
                     next_r.under = (r.op == OP_REAL_DIFFERENCE) ? fp_diff_under : fp_prod_under;
                     next_r.signerr = (r.op == OP_REAL_DIFFERENCE) ? fp_diff_ovf : fp_prod_ovf;
                     if (next_r.under)
                     begin
                        next_r.irq_stat[IRQ_UNDER] = 1'b1;
                     end
                  end
               end
               default:
               begin
               end
            endcase
            if (next_r.st == ST_IDLE)
               next_r.irq_stat[IRQ_DONE] = 1'b1;
         end
         ST_MUL:
         begin
            if (r.rep != r.mplier[31:28])
            begin
               next_r.prod = add_sum;
               next_r.rep = r.rep + 4'h1;
            end
            else if (r.dcnt == DIG_LAST)
            begin
               next_r.acc = r.prod[31:0];
               if (r.op == OP_BCD_PRODUCT_WIDE)
               begin
                  next_r.stack = r.prod[63:32];
               end
               next_r.zero = (r.prod[31:0] == 32'h0000_0000);
               next_r.neg = 1'b0;
               next_r.irq_stat[IRQ_DONE] = 1'b1;
               next_r.st = ST_IDLE;
            end
            else
            begin
               next_r.prod = {r.prod[59:0], 4'h0};
               next_r.mplier = {r.mplier[27:0], 4'h0};
               next_r.rep = 4'h0;
               next_r.dcnt = r.dcnt + 3'h1;
            end
         end
         default:
         begin
            next_r.st = ST_IDLE;
         end
      endcase

      next_r.busy = (next_r.st != ST_IDLE);
      next_r.irq = |(next_r.irq_stat & next_r.irq_mask);
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         r <= '0;
         r.rdy <= 1'b1;
      end
      else
      begin
         r <= next_r;
      end
   end

   // ----------------------------------------
   // outputs, all straight from the state register
   // ----------------------------------------
   assign hreadyout = r.rdy;
   assign hrdata = r.rdata;
   assign hresp = r.resp;
   assign irq = r.irq;
   assign busy = r.busy;
   assign zero_flag = r.zero;
   assign borrow16_flag = r.bor16;
   assign borrow32_flag = r.bor32;
   assign negative_flag = r.neg;
   assign bad_pointer_flag = r.badptr;
   assign float_validity_flag = r.fvalid;
   assign sign_error_flag = r.signerr;
   assign underflow_flag = r.under;
   assign bad_operand_flag = r.badop;

endmodule

// >>> ams_unit_sva.sv
`timescale 1ns/10ps
module ams_unit_chk
   import ams_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       rst_n,
   input wire logic       hsel,
   input wire logic [1:0] htrans,
   input wire logic       hwrite,
   input wire logic       hready,
   input wire logic       hreadyout,
   input wire logic       hresp,
   input wire logic       busy,
   input wire logic       zero_flag,
   input wire logic       borrow16_flag,
   input wire logic       borrow32_flag,
   input wire logic       negative_flag,
   input wire logic       bad_pointer_flag,
   input wire logic       float_validity_flag,
   input wire logic       sign_error_flag,
   input wire logic       underflow_flag,
   input wire logic       bad_operand_flag
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   logic [8:0] f;
   assign f = {bad_operand_flag, underflow_flag, sign_error_flag, float_validity_flag,
      bad_pointer_flag, negative_flag, borrow32_flag, borrow16_flag, zero_flag};
   sequence rd_take;
      hsel && htrans[1] && hready && !hwrite;
   endsequence
   sequence one_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   read_wait_a: assert property (rd_take |=> one_wait) else $error("read wait wrong");
   okay_resp_a: assert property (!hresp) else $error("response not okay");
   flag_hold_a: assert property ($changed(f) |-> $past(busy))
      else $error("flag moved outside an operation");
   borrow32_neg_a: assert property ($rose(borrow32_flag) |-> negative_flag)
      else $error("wide borrow without negative");
   borrow16_neg_a: assert property ($rose(borrow16_flag) |-> negative_flag)
      else $error("short borrow without negative");
   borrow_split_a: assert property ($rose(borrow16_flag) |-> $stable(borrow32_flag))
      else $error("borrow flags not separate");
   bad_ptr_a: assert property ($rose(bad_pointer_flag) |-> $stable({f[8:5], f[3:0]}))
      else $error("bad pointer touched other flags");
   under_zero_a: assert property ($rose(underflow_flag) |-> zero_flag && !negative_flag)
      else $error("underflow result not plus zero");
   busy_bound_a: assert property ($rose(busy) |-> ##[1:120] !busy)
      else $error("operation never ends");
endmodule

// >>> ams_seq.sv
`timescale 1ns/10ps
module ams_seq
   import ams_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel = 1'b0,
   output logic      [31:0] haddr = 32'h0000_0000,
   output logic      [1:0]  htrans = 2'h0,
   output logic             hwrite = 1'b0,
   output logic      [2:0]  hsize = 3'h2,
   output logic      [31:0] hwdata = 32'h0000_0000
);
   // no wait count assumed; the bench timeout cuts a hang
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= {20'h0_0000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk_sys); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hready !== 1'b1);
      q = hrdata;
   endtask
endmodule

// >>> tb_ams_unit.sv
`timescale 1ns/10ps
module tb_ams_unit
   import ams_pkg::*;
;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        hsel, hwrite, hreadyout, hresp, irq, busy;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [8:0]  flg;
   int          error_cnt = 0, check_count = 0, cyc = 0;
   typedef struct {logic [31:0] a, i; logic [15:0] m0, m1; logic [5:0] c;
      logic [31:0] ea; logic [8:0] ef;} ams_row_s;
   ams_row_s rows [16] = '{
      '{32'h0000_1234,32'h0000_0002,16'h0000,16'h0000,6'h23,32'h0000_2468,9'h000},
      '{32'h1234_5678,32'h0000_0002,16'h0000,16'h0000,6'h24,32'h1234_5678,9'h100},
      '{32'h0000_0100,32'h0000_0000,16'h0001,16'h0000,6'h00,32'h0000_0099,9'h000},
      '{32'h1234_5678,32'h0000_000A,16'h0000,16'h0000,6'h20,32'h1234_5678,9'h100},
      '{32'h0000_0099,32'h0000_0099,16'h0000,16'h0000,6'h20,32'h0000_0000,9'h001},
      '{32'h0000_0000,32'h0000_0001,16'h0000,16'h0000,6'h20,32'h9999_9999,9'h00C},
      '{32'h0000_0005,32'h0000_0000,16'h0007,16'h0000,6'h01,32'h0000_9998,9'h00E},
      '{32'h9999_9999,32'h0000_0000,16'h0002,16'h0000,6'h04,32'h9999_9998,9'h006},
      '{32'h3F80_0000,32'h4040_0000,16'h0000,16'h0000,6'h22,32'h4000_0000,9'h026},
      '{32'h4040_0000,32'h3F80_0000,16'h0000,16'h0000,6'h22,32'hC000_0000,9'h02E},
      '{32'h4000_0000,32'h4040_0000,16'h0000,16'h0000,6'h25,32'h40C0_0000,9'h026},
      '{32'h4000_0000,32'h7FC0_0000,16'h0000,16'h0000,6'h22,32'h4000_0000,9'h126},
      '{32'h0080_0000,32'h0080_0000,16'h0000,16'h0000,6'h25,32'h0000_0000,9'h0A7},
      '{32'h0005_0000,32'h0000_0000,16'h001F,16'h0000,6'h10,32'h0005_0000,9'h0B7},
      '{32'h0005_0000,32'h0000_0000,16'h0000,16'h0002,6'h10,32'h0003_0000,9'h0A2},
      '{32'h7F00_0000,32'h7F00_0000,16'h0000,16'h0000,6'h25,32'h7F80_0000,9'h042}};
   ams_unit uut (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hrdata, .hresp, .irq, .busy, .zero_flag(flg[0]),
      .borrow16_flag(flg[1]), .borrow32_flag(flg[2]), .negative_flag(flg[3]),
      .bad_pointer_flag(flg[4]), .float_validity_flag(flg[5]), .sign_error_flag(flg[6]),
      .underflow_flag(flg[7]), .bad_operand_flag(flg[8]));
   ams_seq seq (.clk_sys, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata);
   initial forever #25 clk_sys = ~clk_sys;
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         $display("wrong value at %0t: run timed out", $time);
         end_of_test;
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      seq.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      seq.xfer(1'b0, a, 32'h0000_0000, q);
      chk(q, e);
   endtask
   // poll busy so the next command is never dropped
   task automatic run(input logic [5:0] c);
      wr(OFS_CMD, {26'h000_0000, c});
      seq.xfer(1'b0, OFS_FLAGS, 32'h0000_0000, q);
      while (q[FLG_BUSY] !== 1'b0)
         seq.xfer(1'b0, OFS_FLAGS, 32'h0000_0000, q);
   endtask
   initial
   begin
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(OFS_ACC, 32'h0000_0000);
      rd(OFS_STACK, 32'h0000_0000);
      rd(OFS_FLAGS, 32'h0000_0000);
      wr(12'h020, 32'hFFFF_FFFF);
      rd(12'h020, 32'h0000_0000);
      $display("reset test done");
      foreach (rows[k])
      begin
         wr(OFS_ACC, rows[k].a);
         wr(OFS_IMM, rows[k].i);
         wr(OFS_MEM, {16'h0000, rows[k].m0});
         wr(OFS_MEM + 12'h004, {16'h0000, rows[k].m1});
         run(rows[k].c);
         rd(OFS_ACC, rows[k].ea);
         rd(OFS_FLAGS, {23'h00_0000, rows[k].ef});
         chk({23'h00_0000, flg}, {23'h00_0000, rows[k].ef});
         if (k == 7)
            rd(OFS_STACK, 32'h0000_0001);
         $display("operation test %0d done", k);
      end
      rd(OFS_IRQ_STAT, 32'h0000_000F);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      wr(OFS_IRQ_MASK, 32'h0000_0001);
      rd(OFS_IRQ_MASK, 32'h0000_0001);
      chk({31'h0000_0000, irq}, 32'h0000_0001);
      wr(OFS_IRQ_STAT, 32'h0000_0001);
      rd(OFS_IRQ_STAT, 32'h0000_000E);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      $display("interrupt test done");
      end_of_test;
   end
endmodule
bind ams_unit ams_unit_chk chk_i (.clk_sys, .rst_n, .hsel, .htrans, .hwrite, .hready,
   .hreadyout, .hresp, .busy, .zero_flag, .borrow16_flag, .borrow32_flag, .negative_flag,
   .bad_pointer_flag, .float_validity_flag, .sign_error_flag, .underflow_flag,
   .bad_operand_flag);
